// file: vic_ctrl.sv
/*
  Vectored interrupt controller: 20 sticky source flags in three groups,
  masks, active-low request, acknowledge cycle with a vector, APB registers.
  Assumes source event pulses and the ack strobe come from outside the
  clock domain and are synchronised here; APB is on i_clk_sys.
*/
// Our own choices: register access over APB and the register addresses.
// Function
// - Twenty sticky source flags sit in three status registers: serial, DMA and timer.
// - Three mask registers gate each flag individually from the request.
// - Any active enabled flag drives the active-low request output.
// - A host acknowledge starts an acknowledge cycle that places a vector per the control bits.
// - Two control bits pick non, single or double acknowledge style.
// - In non style no vector is driven on acknowledge.
// - In single style the vector is driven during the first acknowledge.
// - In double style the first acknowledge drives nothing and the second drives the vector.
// - A control bit selects the plain or the coded vector register.
// - The plain vector register outputs the written value unchanged.
// - The coded vector has software upper two bits and a hardware source code in the low six.
// - With several enabled sources active the code names the highest priority one.
// - A control bit swaps serial and DMA priority.
// - Reset held for at least six clocks resets the whole controller.
`timescale 1ns/1ns
module vic_ctrl
  import vic_pkg::*;
(
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_reset,
  input  wire logic [NUM_SOURCES-1:0] i_src_event,
  input  wire logic                   i_irq_ack_n,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [7:0]             i_paddr,
  input  wire logic [31:0]            i_pwdata,
  output logic      [31:0]            o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic                        o_irq_n,
  output logic      [7:0]             o_vector,
  output logic                        o_vector_oe
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  // Three stages; a change counts once stages two and three agree
  logic [NUM_SOURCES-1:0] src_s1_r, src_s2_r, src_s3_r, src_lvl_r;
  logic [2:0]             ack_sync_r;
  logic                   ack_lvl_r, ack_prev_r;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      src_s1_r   <= '0;
      src_s2_r   <= '0;
      src_s3_r   <= '0;
      ack_sync_r <= 3'h7;
    end else begin
      src_s1_r   <= i_src_event;
      src_s2_r   <= src_s1_r;
      src_s3_r   <= src_s2_r;
      ack_sync_r <= {ack_sync_r[1:0], i_irq_ack_n};
    end
  end

  // Per source: the level follows stage three only while two and three agree
  wire [NUM_SOURCES-1:0] src_lvl_nxt;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SOURCES; gi++) begin : g_lvl
      assign src_lvl_nxt[gi] = (src_s2_r[gi] == src_s3_r[gi]) ? src_s3_r[gi] : src_lvl_r[gi];
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      src_lvl_r <= '0;
    end else begin
      src_lvl_r <= src_lvl_nxt;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ack_lvl_r  <= 1'b1;
      ack_prev_r <= 1'b1;
    end else begin
      if (ack_sync_r[1] == ack_sync_r[2]) begin
        ack_lvl_r <= ack_sync_r[2];
      end
      ack_prev_r <= ack_lvl_r;
    end
  end

  // Rise is seen one cycle before the level takes it, so it pulses once
  wire [NUM_SOURCES-1:0] src_rise  = ~src_lvl_r & src_s2_r & src_s3_r;
  wire                   ack_fall  = ~ack_lvl_r & ack_prev_r;
  wire                   ack_rise  = ack_lvl_r & ~ack_prev_r;

  // ************************************************************
  // APB decode
  // ************************************************************
  wire apb_wr   = i_psel & i_penable & i_pwrite;
  wire hit_fa   = (i_paddr == OFS_FLAGS_A);
  wire hit_fb   = (i_paddr == OFS_FLAGS_B);
  wire hit_fc   = (i_paddr == OFS_FLAGS_C);
  wire hit_ma   = (i_paddr == OFS_MASK_A);
  wire hit_mb   = (i_paddr == OFS_MASK_B);
  wire hit_mc   = (i_paddr == OFS_MASK_C);
  wire hit_ctl  = (i_paddr == OFS_CTRL);
  wire hit_pv   = (i_paddr == OFS_PLAIN_V);
  wire hit_cv   = (i_paddr == OFS_CODED_V);
  wire hit_any  = hit_fa | hit_fb | hit_fc | hit_ma | hit_mb | hit_mc | hit_ctl
                  | hit_pv | hit_cv;

  // ************************************************************
  // Flags and masks
  // ************************************************************
  logic [NUM_SOURCES-1:0] flags_r, mask_r;
  logic [3:0]             ctrl_r;
  logic [7:0]             plain_vec_r;
  logic [1:0]             code_hi_r;

  // Write-one-to-clear per group; serial 0-7, DMA 8-15, timer 16-19
  wire [NUM_SOURCES-1:0] w1c = {i_pwdata[NUM_TMR-1:0] & {NUM_TMR{apb_wr & hit_fc}},
                                i_pwdata[7:0] & {NUM_DMA{apb_wr & hit_fb}},
                                i_pwdata[7:0] & {NUM_SER{apb_wr & hit_fa}}};
  // Set wins over a clear in the same cycle
  wire [NUM_SOURCES-1:0] flags_nxt = (flags_r & ~w1c) | src_rise;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      flags_r     <= '0;
      mask_r      <= '0;
      ctrl_r      <= CTRL_RST;
      plain_vec_r <= VECTOR_RST;
      code_hi_r   <= CODE_HI_RST;
    end else begin
      flags_r <= flags_nxt;
      if (apb_wr & hit_ma) mask_r[7:0]   <= i_pwdata[7:0];
      if (apb_wr & hit_mb) mask_r[15:8]  <= i_pwdata[7:0];
      if (apb_wr & hit_mc) mask_r[19:16] <= i_pwdata[NUM_TMR-1:0];
      if (apb_wr & hit_ctl) ctrl_r <= i_pwdata[3:0];
      if (apb_wr & hit_pv) plain_vec_r <= i_pwdata[7:0];
      if (apb_wr & hit_cv) code_hi_r <= i_pwdata[7:CODE_HI_POS];
    end
  end

  wire [NUM_SOURCES-1:0] pend = flags_r & mask_r;
  wire                   any_pend = |pend;

  // ************************************************************
  // Priority encoder
  // ************************************************************
  // Lower index wins inside a group; timers always rank last
  function automatic logic [3:0] low_idx(input logic [7:0] v);
    logic [3:0] r;
    r = 4'h8;
    for (int k = 7; k >= 0; k--) begin
      if (v[k]) r = k[3:0];
    end
    return r;
  endfunction

  wire [3:0] ser_idx = low_idx(pend[7:0]);
  wire [3:0] dma_idx = low_idx(pend[15:8]);
  wire [3:0] tmr_idx = low_idx({4'h0, pend[19:16]});
  wire       swap    = ctrl_r[CTRL_SWAP_POS];
  wire [5:0] ser_code = CODE_SER_BASE | {3'h0, ser_idx[2:0]};
  wire [5:0] dma_code = CODE_DMA_BASE | {3'h0, dma_idx[2:0]};
  wire [5:0] tmr_code = CODE_TMR_BASE | {3'h0, tmr_idx[2:0]};
  wire [5:0] first_code  = swap ? dma_code : ser_code;
  wire       first_hit   = swap ? ~dma_idx[3] : ~ser_idx[3];
  wire [5:0] second_code = swap ? ser_code : dma_code;
  wire       second_hit  = swap ? ~ser_idx[3] : ~dma_idx[3];
  wire [5:0] src_code = first_hit ? first_code :
                        second_hit ? second_code :
                        ~tmr_idx[3] ? tmr_code : 6'h00;
  wire [7:0] coded_vec = {code_hi_r, src_code};

  // ************************************************************
  // Acknowledge cycle
  // ************************************************************
  vic_ack_state_type ack_st_r, ack_st_nxt;
  logic [7:0]        vec_hold_r;
  wire [1:0] style    = {ctrl_r[CTRL_ACK1_POS], ctrl_r[CTRL_ACK0_POS]};
  wire [7:0] vec_sel  = ctrl_r[CTRL_VSEL_POS] ? coded_vec : plain_vec_r;

  always_comb begin
    ack_st_nxt = ack_st_r;
    case (ack_st_r)
      ACK_IDLE: begin
        if (ack_fall) begin
          if (style == ACK_SINGLE) ack_st_nxt = ACK_FIRST;
          else if (style == ACK_DOUBLE) ack_st_nxt = ACK_WAIT2;
          else ack_st_nxt = ACK_IDLE;
        end
      end
      ACK_FIRST:  if (ack_rise) ack_st_nxt = ACK_IDLE;
      ACK_WAIT2:  if (ack_fall) ack_st_nxt = ACK_SECOND;
      ACK_SECOND: if (ack_rise) ack_st_nxt = ACK_IDLE;
      default:    ack_st_nxt = ACK_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ack_st_r   <= ACK_IDLE;
      vec_hold_r <= VECTOR_RST;
    end else begin
      ack_st_r <= ack_st_nxt;
      // Vector is frozen at the driving strobe so it stays stable
      if (ack_st_nxt == ACK_FIRST || ack_st_nxt == ACK_SECOND) begin
        if (ack_st_r != ack_st_nxt) vec_hold_r <= vec_sel;
      end
    end
  end

  assign o_vector    = vec_hold_r;
  assign o_vector_oe = (ack_st_r == ACK_FIRST) | (ack_st_r == ACK_SECOND);
  assign o_irq_n     = ~any_pend;

  // ************************************************************
  // APB read
  // ************************************************************
  wire [31:0] rd_mux =
      hit_fa  ? {24'h0, flags_r[7:0]} :
      hit_fb  ? {24'h0, flags_r[15:8]} :
      hit_fc  ? {28'h0, flags_r[19:16]} :
      hit_ma  ? {24'h0, mask_r[7:0]} :
      hit_mb  ? {24'h0, mask_r[15:8]} :
      hit_mc  ? {28'h0, mask_r[19:16]} :
      hit_ctl ? {28'h0, ctrl_r} :
      hit_pv  ? {24'h0, plain_vec_r} :
      hit_cv  ? {24'h0, coded_vec} : 32'h0;

  // Read data is taken at the end of setup, so the access phase sees a flop
  logic [31:0] prdata_r;
  wire         apb_setup_rd = i_psel & ~i_penable & ~i_pwrite;

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prdata_r <= 32'h0;
    end else begin
      prdata_r <= apb_setup_rd ? rd_mux : 32'h0;
    end
  end

  assign o_prdata  = prdata_r;
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~hit_any;

  // ************************************************************
  // Checks
  // ************************************************************
  a_irq_follows_pend: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    o_irq_n == ~|(flags_r & mask_r)) else $error("irq level wrong");
  // A mask write may legally drop the request, so it is left out here
  a_irq_holds: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (any_pend && w1c == '0 && !(apb_wr && (hit_ma | hit_mb | hit_mc))) |=> !o_irq_n)
    else $error("irq dropped");
  a_mask_blocks: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (mask_r == '0) |-> o_irq_n) else $error("masked flag asserted irq");
  a_flag_sticky: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (flags_r[2] && !w1c[2]) |=> flags_r[2]) else $error("flag lost");
  a_none_no_drive: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_IDLE && style == ACK_NONE && ack_fall) |=> !o_vector_oe)
    else $error("vector driven in non style");
  a_single_drives: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_IDLE && style == ACK_SINGLE && ack_fall) |=> o_vector_oe)
    else $error("single ack missing vector");
  a_single_release: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_FIRST && ack_rise) |=> !o_vector_oe)
    else $error("vector held after ack release");
  a_double_first: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_IDLE && style == ACK_DOUBLE && ack_fall) |=> !o_vector_oe)
    else $error("double ack drove on first");
  a_double_second: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_WAIT2 && ack_fall) |=> o_vector_oe)
    else $error("double ack missing vector on second");
  a_vector_steady: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (o_vector_oe && $past(o_vector_oe)) |-> $stable(o_vector))
    else $error("vector changed while driven");
  a_plain_vector: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_IDLE && style == ACK_SINGLE && ack_fall && !ctrl_r[CTRL_VSEL_POS])
    |=> o_vector == $past(plain_vec_r)) else $error("plain vector wrong");
  a_coded_vector: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (ack_st_r == ACK_WAIT2 && ack_fall && ctrl_r[CTRL_VSEL_POS])
    |=> o_vector == $past(coded_vec)) else $error("coded vector not selected");
  a_coded_hi: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (apb_wr && hit_cv) |=> coded_vec[7:6] == $past(i_pwdata[7:6]))
    else $error("coded upper bits wrong");
  a_serial_wins: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (!swap && (|pend[7:0])) |-> (src_code & 6'h30) == CODE_SER_BASE)
    else $error("serial source not ranked first");
  a_swap_order: assert property (
    @(posedge i_clk_sys) disable iff (i_reset)
    (pend[5] && pend[11])
    |-> src_code == (swap ? (CODE_DMA_BASE | 6'h03) : (CODE_SER_BASE | 6'h05)))
    else $error("priority order wrong");
  a_reset_quiet: assert property (
    @(posedge i_clk_sys)
    i_reset |=> (o_irq_n && !o_vector_oe)) else $error("outputs active after reset");

endmodule // vic_ctrl

// file: vic_pkg.sv
/*
  Package of the vectored interrupt controller: register offsets, field
  positions, reset values and the acknowledge states.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package vic_pkg;
  localparam int unsigned NUM_SOURCES = 20;
  localparam int unsigned NUM_SER     = 8;
  localparam int unsigned NUM_DMA     = 8;
  localparam int unsigned NUM_TMR     = 4;
  localparam int unsigned RESET_MIN_CYCLES = 6;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS_A  = 8'h00;
  localparam logic [7:0] OFS_FLAGS_B  = 8'h04;
  localparam logic [7:0] OFS_FLAGS_C  = 8'h08;
  localparam logic [7:0] OFS_MASK_A   = 8'h0c;
  localparam logic [7:0] OFS_MASK_B   = 8'h10;
  localparam logic [7:0] OFS_MASK_C   = 8'h14;
  localparam logic [7:0] OFS_CTRL     = 8'h18;
  localparam logic [7:0] OFS_PLAIN_V  = 8'h1c;
  localparam logic [7:0] OFS_CODED_V  = 8'h20;

  // Control register fields and the coded vector upper-bit position
  localparam int unsigned CTRL_ACK0_POS  = 0;
  localparam int unsigned CTRL_ACK1_POS  = 1;
  localparam int unsigned CTRL_VSEL_POS  = 2;
  localparam int unsigned CTRL_SWAP_POS  = 3;
  localparam int unsigned CODE_HI_POS    = 6;

  // Reset values
  localparam logic [3:0] CTRL_RST    = 4'h0;
  localparam logic [7:0] VECTOR_RST  = 8'h00;
  localparam logic [1:0] CODE_HI_RST = 2'h0;
  localparam logic [7:0] MASK_RST    = 8'h00;

  // Acknowledge styles
  localparam logic [1:0] ACK_NONE   = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_DOUBLE = 2'h2;

  // Source code offsets
  localparam logic [5:0] CODE_SER_BASE = 6'h00;
  localparam logic [5:0] CODE_DMA_BASE = 6'h10;
  localparam logic [5:0] CODE_TMR_BASE = 6'h20;

  typedef enum logic [1:0] {
    ACK_IDLE   = 2'b00,
    ACK_FIRST  = 2'b01,
    ACK_WAIT2  = 2'b10,
    ACK_SECOND = 2'b11
  } vic_ack_state_type;
endpackage

// file: vic_host.sv
/*
  Host model: answers the active-low request with acknowledge strobes
  and records whether and which vector the controller drove.
  Assumes the bench calls ack_once and that clocks run at i_clk_sys.
*/
`timescale 1ns/1ns
module vic_host (
  input  wire logic       i_clk_sys,
  input  wire logic       i_irq_n,
  input  wire logic [7:0] i_vector,
  input  wire logic       i_vector_oe,
  output logic            o_irq_ack_n
);
  initial o_irq_ack_n = 1'b1;

  // ***************
  // Acknowledge
  // ***************
  // Low and high phases stay at least 3 clocks so the synchroniser sees them
  task automatic ack_once(input int low_cyc, output logic seen, output logic [7:0] vec);
    int n;
    seen = 1'b0;
    vec = 8'h00;
    n = 0;
    while (i_irq_n !== 1'b0 && n < 50) begin
      @(posedge i_clk_sys);
      n++;
    end
    @(posedge i_clk_sys);
    o_irq_ack_n <= 1'b0;
    repeat (low_cyc) begin
      @(posedge i_clk_sys);
      if (i_vector_oe === 1'b1) begin
        seen = 1'b1;
        vec = i_vector;
      end
    end
    o_irq_ack_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
  endtask
endmodule // vic_host

// file: test_vic_ctrl.sv
/*
  Self-checking bench of vic_ctrl: APB master, source pulses, host model.
  Assumes zero-wait APB and the style and code encodings of vic_pkg.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module test_vic_ctrl;
  import vic_pkg::*;
  logic                   clk, reset, ack_n, irq_n, oe, psel, penable, pwrite;
  logic                   pready, pslverr, err, s1, s2;
  logic [NUM_SOURCES-1:0] ev;
  logic [7:0]             paddr, vec, v1, v2;
  logic [31:0]            pwdata, prdata, rd;
  int                     n_mismatch = 0;
  int                     n_checks = 0;

  vic_ctrl i_vic_ctrl (.i_clk_sys(clk), .i_reset(reset), .i_src_event(ev), .i_irq_ack_n(ack_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq_n(irq_n),
    .o_vector(vec), .o_vector_oe(oe));
  vic_host i_vic_host (.i_clk_sys(clk), .i_irq_n(irq_n), .i_vector(vec), .i_vector_oe(oe),
    .o_irq_ack_n(ack_n));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ***************
  // Bus and stimulus
  // ***************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse is held 4 clocks, past the synchroniser's minimum of 2
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    repeat (4) @(posedge clk);
    ev[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  function automatic logic [31:0] code(input logic [1:0] hi, input logic [5:0] c);
    return {24'h0, hi, c};
  endfunction

  // ***************
  // Scenarios
  // ***************
  task automatic t_reset;
    logic [7:0] ofs [9] = '{OFS_FLAGS_A, OFS_FLAGS_B, OFS_FLAGS_C, OFS_MASK_A, OFS_MASK_B,
                            OFS_MASK_C, OFS_CTRL, OFS_PLAIN_V, OFS_CODED_V};
    `CHK(irq_n, 1'b1)
    `CHK(oe, 1'b0)
    `CHK(pready, 1'b1)
    foreach (ofs[k]) begin
      apb(1'b0, ofs[k], 32'h0);
      `CHK(rd, 32'h0)
      `CHK(err, 1'b0)
    end
    apb(1'b0, 8'h3c, 32'h0);
    `CHK(err, 1'b1)
  endtask

  task automatic t_mask;
    pulse(2);
    apb(1'b0, OFS_FLAGS_A, 32'h0);
    `CHK(rd, 32'h4)
    `CHK(irq_n, 1'b1)
    apb(1'b1, OFS_MASK_A, 32'h4);
    @(negedge clk);
    `CHK(irq_n, 1'b0)
    apb(1'b1, OFS_MASK_A, 32'h0);
    @(negedge clk);
    `CHK(irq_n, 1'b1)
    apb(1'b1, OFS_MASK_A, 32'h4);
    apb(1'b1, OFS_FLAGS_A, 32'h4);
    @(negedge clk);
    `CHK(irq_n, 1'b1)
  endtask

  task automatic t_prio;
    apb(1'b1, OFS_MASK_A, 32'hff);
    apb(1'b1, OFS_MASK_B, 32'hff);
    apb(1'b1, OFS_MASK_C, 32'h0f);
    apb(1'b1, OFS_CODED_V, 32'hbf);
    pulse(5);
    pulse(11);
    pulse(17);
    apb(1'b0, OFS_FLAGS_B, 32'h0);
    `CHK(rd, 32'h8)
    apb(1'b0, OFS_FLAGS_C, 32'h0);
    `CHK(rd, 32'h2)
    apb(1'b0, OFS_CODED_V, 32'h0);
    `CHK(rd, code(2'h2, CODE_SER_BASE + 6'd5))
    apb(1'b1, OFS_CTRL, 32'h8);
    apb(1'b0, OFS_CODED_V, 32'h0);
    `CHK(rd, code(2'h2, CODE_DMA_BASE + 6'd3))
    apb(1'b1, OFS_FLAGS_B, 32'h8);
    apb(1'b1, OFS_FLAGS_A, 32'h20);
    apb(1'b0, OFS_CODED_V, 32'h0);
    `CHK(rd, code(2'h2, CODE_TMR_BASE + 6'd1))
    apb(1'b1, OFS_FLAGS_C, 32'h2);
    apb(1'b1, OFS_CTRL, 32'h0);
    @(negedge clk);
    `CHK(irq_n, 1'b1)
  endtask

  task automatic t_ack;
    // Style code 3 is spare and must behave as non-acknowledge
    logic [1:0] sty [4] = '{ACK_NONE, ACK_SINGLE, ACK_DOUBLE, 2'h3};
    pulse(1);
    apb(1'b1, OFS_PLAIN_V, 32'h5a);
    apb(1'b1, OFS_CODED_V, 32'hc0);
    foreach (sty[k]) begin
      apb(1'b1, OFS_CTRL, {30'h0, sty[k]});
      i_vic_host.ack_once(8, s1, v1);
      i_vic_host.ack_once(8, s2, v2);
      `CHK(s1, 1'(sty[k] == ACK_SINGLE))
      if (sty[k] != ACK_SINGLE) `CHK(s2, 1'(sty[k] == ACK_DOUBLE))
      if (sty[k] == ACK_SINGLE) `CHK(v1, 8'h5a)
      if (sty[k] == ACK_DOUBLE) `CHK(v2, 8'h5a)
    end
    // Slow host on the coded vector
    apb(1'b1, OFS_CTRL, 32'h6);
    i_vic_host.ack_once(12, s1, v1);
    i_vic_host.ack_once(12, s2, v2);
    `CHK(s1, 1'b0)
    `CHK(v2, code(2'h3, CODE_SER_BASE + 6'd1) & 8'hff)
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    ev = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (RESET_MIN_CYCLES) @(posedge clk);
    reset <= 1'b0;
    t_reset;
    t_mask;
    t_prio;
    t_ack;
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    final_report;
  end
endmodule // test_vic_ctrl
